// file: test_windowed_watchdog.sv
// Purpose: self-checking bench for the windowed watchdog core
// Assumes: short internal period so the windows fit a short run
// Notes: stuck-low trigger needs 5 ms of real time and is left to the design's own checks
`timescale 1ns/10ps
module test_windowed_watchdog;
  import wwdg_pkg::*;
  localparam int unsigned P = 100;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic mode_in = 1'b0;
  logic supervise_disable_n = 1'b1;
  wire logic trigger_in;
  wire logic reset_out_n;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  int falls = 0;
  int exp_falls = 0;
  int run = 0;
  int last_len = 0;
  logic prev = 1'b0;
  int gaps[$] = '{1950, 1900, 2000, 1200};

  always #5 clock = ~clock;

  wwdg_core #(.PERIOD_CYC(P)) uut (
    .clock(clock),
    .rst_n(rst_n),
    .trigger_in(trigger_in),
    .mode_in(mode_in),
    .supervise_disable_n(supervise_disable_n),
    .reset_out_n(reset_out_n)
  );

  wwdg_mcu mcu (.clock(clock), .trigger_in(trigger_in));

  // watch the output: count resets and length of the last reset pulse
  always @(negedge clock) begin
    if (reset_out_n === 1'b0 && prev === 1'b1) falls++;
    if (reset_out_n === 1'b0) run++;
    else if (run != 0) begin
      last_len = run;
      run = 0;
    end
    prev = reset_out_n;
  end

  // model: a trigger before the closed window ends costs one reset
  function automatic int resets_for(input int rise_gap, input logic long_mode);
    int closed;
    closed = (long_mode ? WWDG_LONG_CLOSED : WWDG_SHORT_CLOSED) * P;
    return (rise_gap < closed - P) ? 1 : 0;
  endfunction

  task automatic chk(input logic seen, input logic exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: output %b, model %b", $time, seen, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask

  // trigger whose rising edge lands rise_gap cycles after the last one
  task automatic trig_at(input int rise_gap);
    int w;
    w = WWDG_TRIG_MIN_CYC + $urandom % 200;
    mcu.pulse(rise_gap - w - 30, w);
    exp_falls += resets_for(rise_gap, mode_in);
    idle(30);
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // a hang is cut short well past the expected run length
  always @(posedge clock) begin
    cycles++;
    if (cycles == 90000) begin
      n_mismatch++;
      end_of_test;
    end
  end

  initial begin
    void'($urandom(32'h85EF34D2));
    idle(20);
    rst_n = 1'b1;
    idle(900);
    chk(reset_out_n, 1'b0);
    idle(250);
    chk(reset_out_n, 1'b1);
    // sync, then open-window triggers and one early trigger
    mcu.pulse(10, 1100);
    idle(30);
    chk(reset_out_n, 1'b1);
    foreach (gaps[i]) begin
      trig_at(gaps[i]);
      chk(falls == exp_falls, 1'b1);
    end
    chk(falls == 1, 1'b1);
    idle(450);
    chk(last_len >= 300 && last_len <= 405, 1'b1);
    // missing trigger after sync in short windows
    mcu.pulse(10, 1100);
    idle(2350);
    chk(reset_out_n, 1'b1);
    idle(300);
    exp_falls++;
    chk(falls == exp_falls, 1'b1);
    idle(450);
    // long windows: the same spacing now falls in the closed window
    mode_in = 1'b1;
    mcu.pulse(10, 1100);
    trig_at(1950);
    chk(falls == exp_falls, 1'b1);
    chk(exp_falls == 3, 1'b1);
    idle(450);
    // drop to short windows as the sync trigger rises, before the closed window starts
    mcu.pulse(10, 1100);
    mode_in = 1'b0;
    trig_at(1950);
    chk(falls == exp_falls, 1'b1);
    // disabled watchdog gives no reset although no trigger comes
    supervise_disable_n = 1'b0;
    idle(3000);
    chk(falls == exp_falls, 1'b1);
    chk(reset_out_n, 1'b1);
    // re-enable, then no sync trigger at all
    supervise_disable_n = 1'b1;
    idle(44800);
    chk(reset_out_n, 1'b1);
    idle(400);
    exp_falls++;
    chk(falls == exp_falls, 1'b1);
    end_of_test;
  end
endmodule

// file: wwdg_core.sv
// Purpose: windowed watchdog supervising a microcontroller trigger
// Assumes: pins are asynchronous; pull-ups live in the pad ring
// Notes: one internal period is a tick enable from a divider
`timescale 1ns/10ps
module wwdg_core
  import wwdg_pkg::*;
#(
  parameter int unsigned PERIOD_CYC = WWDG_PERIOD_CYC // clocks per internal period
)
(
  input wire logic clock, // system clock, 100 MHz
  input wire logic rst_n, // synchronous reset, stands for supply good, active low
  input wire logic trigger_in, // trigger pin from the microcontroller
  input wire logic mode_in, // window length select, high is long
  input wire logic supervise_disable_n, // disable pin, active low
  output logic reset_out_n // reset to the microcontroller, active low
);
  typedef struct packed {
    wwdg_pins_t meta;
    wwdg_pins_t pins;
    logic [WWDG_DIV_W-1:0] div;
    logic tick;
    wwdg_state_t st;
    logic [WWDG_PCNT_W-1:0] cnt;
    logic out_n;
    logic [WWDG_DIV_W+1:0] hold;
  } wwdg_core_t;

  wwdg_core_t s, next_s;
  wwdg_trig_t trig_q;
  logic [WWDG_PCNT_W-1:0] closed_len;
  logic [WWDG_PCNT_W-1:0] open_len;

  localparam logic [WWDG_DIV_W-1:0] DIV_LAST = WWDG_DIV_W'(PERIOD_CYC - 1);
  localparam logic [WWDG_PCNT_W-1:0] POR_LAST = WWDG_PCNT_W'(WWDG_POR_PERIODS - 1);
  localparam logic [WWDG_PCNT_W-1:0] SYNC_LAST = WWDG_PCNT_W'(WWDG_SYNC_PERIODS - 1);
  localparam logic [WWDG_PCNT_W-1:0] PULSE_LAST = WWDG_PCNT_W'(WWDG_PULSE_PERIODS - 1);
  localparam logic [WWDG_PCNT_W-1:0] SC_LAST = WWDG_PCNT_W'(WWDG_SHORT_CLOSED - 1);
  localparam logic [WWDG_PCNT_W-1:0] SO_LAST = WWDG_PCNT_W'(WWDG_SHORT_OPEN - 1);
  localparam logic [WWDG_PCNT_W-1:0] LC_LAST = WWDG_PCNT_W'(WWDG_LONG_CLOSED - 1);
  localparam logic [WWDG_PCNT_W-1:0] LO_LAST = WWDG_PCNT_W'(WWDG_LONG_OPEN - 1);
  // longest stay in one reset pulse, in clocks; the first period may be partial
  localparam logic [WWDG_DIV_W+1:0] PULSE_MAX =
    (WWDG_DIV_W+2)'(WWDG_PULSE_PERIODS * PERIOD_CYC);

  // pulse width qualifier runs on the synchronised trigger level
  wwdg_trig u_trig (
    .clock(clock),
    .rst_n(rst_n),
    .trig(s.pins.trigger),
    .result(trig_q)
  );

  // window lengths follow the live mode level
  // mode low mid-window falls back to short lengths
  always_comb begin
    if (s.pins.long_mode) begin
      closed_len = LC_LAST;
      open_len = LO_LAST;
    end else begin
      closed_len = SC_LAST;
      open_len = SO_LAST;
    end
  end

  // next-state logic; the window counter restarts on every state change
  always_comb begin
    next_s = s;
    next_s.meta.trigger = trigger_in;
    next_s.meta.long_mode = mode_in;
    next_s.meta.enable = supervise_disable_n;
    next_s.pins = s.meta;
    // internal period divider
    next_s.tick = 1'b0;
    if (s.div == DIV_LAST) begin
      next_s.div = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.div = s.div + 1'b1;
    end
    if (s.tick) begin
      next_s.cnt = s.cnt + 1'b1;
    end
    case (s.st)
      WWDG_ST_POR: begin
        if (s.tick && s.cnt == POR_LAST) begin
          next_s.st = WWDG_ST_SYNC;
          next_s.cnt = '0;
        end
      end
      WWDG_ST_SYNC: begin
        if (trig_q.valid) begin
          next_s.st = WWDG_ST_CLOSED;
          next_s.cnt = '0;
        end else if (s.tick && s.cnt == SYNC_LAST) begin
          next_s.st = WWDG_ST_PULSE;
          next_s.cnt = '0;
        end
      end
      WWDG_ST_CLOSED: begin
        if (trig_q.valid) begin
          next_s.st = WWDG_ST_PULSE;
          next_s.cnt = '0;
        end else if (s.tick && s.cnt >= closed_len) begin
          next_s.st = WWDG_ST_OPEN;
          next_s.cnt = '0;
        end
      end
      WWDG_ST_OPEN: begin
        if (trig_q.valid) begin
          next_s.st = WWDG_ST_CLOSED;
          next_s.cnt = '0;
        end else if (s.tick && s.cnt >= open_len) begin
          next_s.st = WWDG_ST_PULSE;
          next_s.cnt = '0;
        end
      end
      WWDG_ST_PULSE: begin
        if (trig_q.valid) begin
          next_s.cnt = '0;
        end else if (s.tick && s.cnt == PULSE_LAST) begin
          next_s.st = WWDG_ST_SYNC;
          next_s.cnt = '0;
        end
      end
      WWDG_ST_ERROR: begin
        // hold reset until trigger rises, then a fresh sync
        if (!trig_q.stuck) begin
          next_s.st = WWDG_ST_SYNC;
          next_s.cnt = '0;
        end
      end
      WWDG_ST_OFF: begin
        if (s.pins.enable) begin
          next_s.st = WWDG_ST_SYNC;
          next_s.cnt = '0;
        end
      end
      default: begin
        next_s.st = WWDG_ST_POR;
        next_s.cnt = '0;
      end
    endcase
    // stuck trigger overrides any state but power-on; disable below still wins
    if (trig_q.stuck && s.st != WWDG_ST_POR) begin
      next_s.st = WWDG_ST_ERROR;
      next_s.cnt = '0;
    end
    // disable wins over supervision, but not over power-on delay
    if (!s.pins.enable && s.st != WWDG_ST_POR) begin
      next_s.st = WWDG_ST_OFF;
      next_s.cnt = '0;
    end
    // reset output low only in reset-giving states
    next_s.out_n = !(next_s.st == WWDG_ST_POR || next_s.st == WWDG_ST_PULSE ||
                     next_s.st == WWDG_ST_ERROR);
    // helper: clocks spent in one reset pulse, cleared on restart or exit
    if (s.st == WWDG_ST_PULSE && next_s.st == WWDG_ST_PULSE && !trig_q.valid) begin
      next_s.hold = s.hold + 1'b1;
    end else begin
      next_s.hold = '0;
    end
  end

  // reset holds the output low; pins settle high like the pull-ups
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s <= '{meta: '1, pins: '1, div: '0, tick: 1'b0, st: WWDG_ST_POR,
             cnt: '0, out_n: 1'b0, hold: '0};
    end else begin
      s <= next_s;
    end
  end

  assign reset_out_n = s.out_n;

  // open mode pin reads high through the pad pull-up
  // open disable pin reads high through the pad pull-up

  sequence seq_pulse_enter;
    s.st != WWDG_ST_PULSE ##1 s.st == WWDG_ST_PULSE;
  endsequence

  sequence seq_good_open;
    s.st == WWDG_ST_OPEN && trig_q.valid && !trig_q.stuck && s.pins.enable;
  endsequence

  a_out_low_states: assert property (@(posedge clock) disable iff (!rst_n)
    (s.st == WWDG_ST_PULSE || s.st == WWDG_ST_ERROR) |-> !reset_out_n)
    else $error("reset output high while giving reset");
  a_por_output_low: assert property (@(posedge clock) disable iff (!rst_n)
    s.st == WWDG_ST_POR |-> !reset_out_n)
    else $error("reset output high during power-on delay");
  a_sync_to_closed: assert property (@(posedge clock) disable iff (!rst_n)
    (s.st == WWDG_ST_SYNC && trig_q.valid && !trig_q.stuck && s.pins.enable)
    |=> s.st == WWDG_ST_CLOSED)
    else $error("sync trigger did not open windows");
  a_early_reset: assert property (@(posedge clock) disable iff (!rst_n)
    (s.st == WWDG_ST_CLOSED && trig_q.valid && !trig_q.stuck && s.pins.enable)
    |=> s.st == WWDG_ST_PULSE ##0 !reset_out_n)
    else $error("early trigger did not reset");
  a_open_good: assert property (@(posedge clock) disable iff (!rst_n)
    seq_good_open |=> s.st == WWDG_ST_CLOSED && reset_out_n)
    else $error("open window trigger mishandled");
  a_pulse_from: assert property (@(posedge clock) disable iff (!rst_n)
    seq_pulse_enter |-> $past(s.st) inside {WWDG_ST_SYNC, WWDG_ST_CLOSED,
                                           WWDG_ST_OPEN})
    else $error("reset pulse from an unexpected state");
  a_stuck_error: assert property (@(posedge clock) disable iff (!rst_n)
    (trig_q.stuck && s.pins.enable && s.st != WWDG_ST_POR) |=> !reset_out_n)
    else $error("stuck trigger did not hold reset");
  a_disable_off: assert property (@(posedge clock) disable iff (!rst_n)
    (!s.pins.enable && s.st != WWDG_ST_POR) |=> s.st == WWDG_ST_OFF && reset_out_n)
    else $error("disable did not stop supervision");
  a_pulse_restart: assert property (@(posedge clock) disable iff (!rst_n)
    (s.st == WWDG_ST_PULSE && trig_q.valid && !trig_q.stuck && s.pins.enable)
    |=> s.st == WWDG_ST_PULSE && s.cnt == '0)
    else $error("pulse timer not restarted");

  // no trigger, no stuck line and supervision on: timers alone decide
  sequence seq_quiet;
    !trig_q.valid && !trig_q.stuck && s.pins.enable;
  endsequence

  // counters never pass their own limits
  a_por_count: assert property (@(posedge clock) disable iff (!rst_n)
    s.st == WWDG_ST_POR |-> s.cnt <= POR_LAST)
    else $error("power-on count past its limit");
  a_sync_count: assert property (@(posedge clock) disable iff (!rst_n)
    s.st == WWDG_ST_SYNC |-> s.cnt <= SYNC_LAST)
    else $error("sync count past its limit");

  // sync timeout gives a reset pulse
  a_sync_timeout: assert property (@(posedge clock) disable iff (!rst_n)
    (s.st == WWDG_ST_SYNC && s.tick && s.cnt == SYNC_LAST) ##0 seq_quiet
    |=> s.st == WWDG_ST_PULSE && !reset_out_n)
    else $error("sync timeout did not reset");

  // pulse count bounded and pulse ends back in sync
  a_pulse_count: assert property (@(posedge clock) disable iff (!rst_n)
    s.st == WWDG_ST_PULSE |-> s.cnt <= PULSE_LAST)
    else $error("pulse count past its limit");
  a_pulse_length: assert property (@(posedge clock) disable iff (!rst_n)
    s.st == WWDG_ST_PULSE |-> s.hold < PULSE_MAX)
    else $error("reset pulse longer than four periods");
  a_pulse_to_sync: assert property (@(posedge clock) disable iff (!rst_n)
    (s.st == WWDG_ST_PULSE && s.tick && s.cnt == PULSE_LAST) ##0 seq_quiet
    |=> s.st == WWDG_ST_SYNC && reset_out_n)
    else $error("reset pulse did not end");

  // closed window hands over to the open window
  a_closed_to_open: assert property (@(posedge clock) disable iff (!rst_n)
    (s.st == WWDG_ST_CLOSED && s.tick && s.cnt >= closed_len) ##0 seq_quiet
    |=> s.st == WWDG_ST_OPEN && reset_out_n)
    else $error("closed window did not open");

  // in short mode the closed window ends at the short length
  a_short_closed: assert property (@(posedge clock) disable iff (!rst_n)
    (s.st == WWDG_ST_CLOSED && !s.pins.long_mode && s.tick && s.cnt == SC_LAST)
    ##0 seq_quiet |=> s.st == WWDG_ST_OPEN)
    else $error("short closed window overran");

  a_long_bound: assert property (@(posedge clock) disable iff (!rst_n)
    (s.st == WWDG_ST_CLOSED || s.st == WWDG_ST_OPEN) |-> s.cnt <= LC_LAST)
    else $error("window count past the long limit");

  // open window timeout gives a reset pulse
  a_open_timeout: assert property (@(posedge clock) disable iff (!rst_n)
    (s.st == WWDG_ST_OPEN && s.tick && s.cnt >= open_len) ##0 seq_quiet
    |=> s.st == WWDG_ST_PULSE && !reset_out_n)
    else $error("open window timeout did not reset");

  // long open window ends at its own length with a reset
  a_long_timeout: assert property (@(posedge clock) disable iff (!rst_n)
    (s.st == WWDG_ST_OPEN && s.pins.long_mode && s.tick && s.cnt == LO_LAST)
    ##0 seq_quiet |=> s.st == WWDG_ST_PULSE)
    else $error("long open window timeout did not reset");

  // long mode trigger in the open window keeps the output high
  a_long_good: assert property (@(posedge clock) disable iff (!rst_n)
    (seq_good_open ##0 s.pins.long_mode) |=> s.st == WWDG_ST_CLOSED && reset_out_n)
    else $error("long open window trigger mishandled");

  // long mode trigger in the closed window gives a reset
  a_long_early: assert property (@(posedge clock) disable iff (!rst_n)
    (s.st == WWDG_ST_CLOSED && s.pins.long_mode && trig_q.valid && !trig_q.stuck &&
     s.pins.enable) |=> s.st == WWDG_ST_PULSE)
    else $error("long early trigger did not reset");

  // supervising and disabled states keep the output high
  a_out_high_states: assert property (@(posedge clock) disable iff (!rst_n)
    (s.st == WWDG_ST_SYNC || s.st == WWDG_ST_CLOSED || s.st == WWDG_ST_OPEN ||
     s.st == WWDG_ST_OFF) |-> reset_out_n)
    else $error("reset output low outside a reset state");

  // released trigger line leaves the error state for sync
  a_error_release: assert property (@(posedge clock) disable iff (!rst_n)
    s.st == WWDG_ST_ERROR ##0 seq_quiet |=> s.st == WWDG_ST_SYNC)
    else $error("error state not left after trigger rose");

  // re-enabled watchdog starts with a fresh sync
  a_off_release: assert property (@(posedge clock) disable iff (!rst_n)
    s.st == WWDG_ST_OFF ##0 seq_quiet |=> s.st == WWDG_ST_SYNC)
    else $error("re-enable did not return to sync");
endmodule

// file: wwdg_mcu.sv
// Purpose: microcontroller model that sends low trigger pulses to the watchdog
// Assumes: push-pull trigger output that idles high
// Notes: all edges are placed on the falling clock edge, off the sampling edge
`timescale 1ns/10ps
module wwdg_mcu (
  input wire logic clock, // system clock
  output logic trigger_in // trigger line to the watchdog
);
  initial trigger_in = 1'b1;
  task automatic pulse(input int gap, input int width);
    repeat (gap) @(negedge clock);
    trigger_in = 1'b0;
    repeat (width) @(negedge clock);
    trigger_in = 1'b1;
  endtask
endmodule

// file: wwdg_pkg.sv
// Purpose: shared constants and types for the windowed watchdog
// Assumes: 100 MHz clock, internal period of 880 us as default
// Notes: window, delay and pulse counts are in units of the internal period; trigger widths are in microseconds
package wwdg_pkg;
  localparam int unsigned WWDG_CLK_MHZ = 100;
  localparam int unsigned WWDG_PERIOD_US = 880;
  localparam int unsigned WWDG_PERIOD_CYC = WWDG_PERIOD_US * WWDG_CLK_MHZ;
  localparam int unsigned WWDG_POR_PERIODS = 10;
  localparam int unsigned WWDG_SYNC_PERIODS = 450;
  localparam int unsigned WWDG_SHORT_CLOSED = 15;
  localparam int unsigned WWDG_SHORT_OPEN = 10;
  localparam int unsigned WWDG_LONG_CLOSED = 1500;
  localparam int unsigned WWDG_LONG_OPEN = 1000;
  localparam int unsigned WWDG_PULSE_PERIODS = 4;
  localparam int unsigned WWDG_TRIG_MIN_US = 10;
  localparam int unsigned WWDG_TRIG_MAX_US = 5000;
  // least and longest widths convert exactly: microseconds times clock MHz
  localparam int unsigned WWDG_TRIG_MIN_CYC = WWDG_TRIG_MIN_US * WWDG_CLK_MHZ;
  localparam int unsigned WWDG_TRIG_MAX_CYC = WWDG_TRIG_MAX_US * WWDG_CLK_MHZ;
  localparam int WWDG_PCNT_W = 12;
  localparam int WWDG_TCNT_W = 20;
  localparam int WWDG_DIV_W = 24;

  typedef enum logic [2:0] {
    WWDG_ST_POR,
    WWDG_ST_SYNC,
    WWDG_ST_CLOSED,
    WWDG_ST_OPEN,
    WWDG_ST_PULSE,
    WWDG_ST_ERROR,
    WWDG_ST_OFF
  } wwdg_state_t;

  // pins seen by the watchdog after synchronisation
  typedef struct packed {
    logic trigger;
    logic long_mode;
    logic enable;
  } wwdg_pins_t;

  // trigger qualifier result
  typedef struct packed {
    logic valid;
    logic stuck;
  } wwdg_trig_t;
endpackage

// file: wwdg_trig.sv
// Purpose: qualify low pulses on the synchronised trigger line
// Assumes: trig is already synchronised to clock
// Notes: valid is a one-cycle pulse at the rising edge of a good pulse
`timescale 1ns/10ps
module wwdg_trig
  import wwdg_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic trig, // synchronised trigger level
  output wwdg_pkg::wwdg_trig_t result // valid pulse and stuck-low level
);
  typedef struct packed {
    logic prev;
    logic [WWDG_TCNT_W-1:0] width;
    wwdg_trig_t out;
  } wwdg_tq_t;

  wwdg_tq_t s, next_s;
  localparam logic [WWDG_TCNT_W-1:0] MIN_W = WWDG_TCNT_W'(WWDG_TRIG_MIN_CYC);
  localparam logic [WWDG_TCNT_W-1:0] MAX_W = WWDG_TCNT_W'(WWDG_TRIG_MAX_CYC);

  // width counter saturates just past the limit so stuck stays flagged
  always_comb begin
    next_s = s;
    next_s.prev = trig;
    next_s.out.valid = 1'b0;
    if (!trig) begin
      if (s.width <= MAX_W) begin
        next_s.width = s.width + 1'b1;
      end
    end else begin
      next_s.width = '0;
    end
    if (trig && !s.prev && s.width >= MIN_W && s.width <= MAX_W) begin
      next_s.out.valid = 1'b1;
    end
    next_s.out.stuck = !trig && (s.width > MAX_W);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s <= '{prev: 1'b1, width: '0, out: '0};
    end else begin
      s <= next_s;
    end
  end

  assign result = s.out;

  // a valid pulse only follows a low level that just ended
  a_valid_after_low: assert property (@(posedge clock) disable iff (!rst_n)
    s.out.valid |-> $past(trig) && !$past(trig, 2))
    else $error("valid trigger without a preceding low");
endmodule
